/* File: periph_model.sv */
// peripheral model driving the edge-wait trigger source lines
module periph_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] level_i,
  output logic      [15:0] src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // sources move only on the clock edge, as synced peripheral events do
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) src_o <= 16'h0000;
    else src_o <= level_i;
  end
endmodule

/* File: seq_pkg.sv */
// package: step sequencer constants, register map and carrier types
package seq_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] STATUS_OFF   = 8'h04;
  localparam logic [7:0] BTE_OFF      = 8'h08;
  localparam logic [7:0] T0LIM_OFF    = 8'h0c;
  localparam logic [7:0] T1LIM_OFF    = 8'h10;
  localparam logic [7:0] SDLIM_OFF    = 8'h14;
  localparam logic [7:0] C0LIM_OFF    = 8'h18;
  localparam logic [7:0] C1LIM_OFF    = 8'h1c;
  localparam logic [7:0] HOLD_OFF     = 8'h20;
  localparam logic [7:0] ADJ_OFF      = 8'h24;
  localparam logic [7:0] LIT0_OFF     = 8'h28;
  localparam logic [7:0] QPTR_OFF     = 8'h2c;
  localparam logic [7:0] CNT_OFF      = 8'h30;
  localparam logic [7:0] ADCSEL_OFF   = 8'h34;
  localparam logic [7:0] QUEUE_OFF    = 8'h40;
  localparam logic [7:0] QUEUE_END    = 8'h7c;
  // control bit positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_START_BIT= 1;
  localparam int CTRL_SWT_BIT  = 2;
  localparam int CTRL_SDEN_BIT = 3;
  // command codes (upper nibble)
  localparam logic [3:0] CMD_CONTROL = 4'h0;
  localparam logic [3:0] CMD_ADDCOPY = 4'h1;
  localparam logic [2:0] CMD_STROBE  = 3'h1;
  localparam logic [3:0] CMD_WAITHI  = 4'h4;
  localparam logic [3:0] CMD_WAITLO  = 4'h5;
  localparam logic [3:0] CMD_IRQ     = 4'h7;
  localparam logic [2:0] CMD_TRIG    = 3'h4;
  localparam logic [2:0] CMD_JUMP    = 3'h5;
  localparam logic [2:0] CMD_LOOP0   = 3'h6;
  localparam logic [2:0] CMD_LOOP1   = 3'h7;
  // control operands
  localparam logic [3:0] OPT_SD_OFF  = 4'h2;
  localparam logic [3:0] OPT_SD_ON   = 4'h6;
  localparam logic [3:0] OPT_TMR0    = 4'h8;
  localparam logic [3:0] OPT_TMR1    = 4'h9;
  localparam logic [3:0] OPT_SWT     = 4'hb;
  localparam logic [3:0] OPT_CPY_C0  = 4'hc;
  localparam logic [3:0] OPT_CPY_C1  = 4'hd;
  localparam logic [3:0] OPT_CPY_L0  = 4'he;
  localparam logic [3:0] OPT_BCAST   = 4'hf;
  localparam logic [3:0] OPT_IRQ_MAX = 4'h3;
  localparam logic [2:0] TGT_LAST    = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] REG_RESET  = 16'h0000;

  // decoded step byte
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] opt;
  } step_t;

  // one pulse bundle toward the peripherals
  typedef struct packed {
    logic [31:0] trig;
    logic [3:0]  irq;
  } pulse_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_WAIT,
    ST_DELAY
  } seq_state_t;
endpackage

/* File: step_command_sequencer_decode_tb.sv */
// bench for the step sequencer: registers, program run, edge waits
module step_command_sequencer_decode_tb
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd_d, trig;
  logic [15:0] lvl, src;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [3:0] irq;
  logic [5:0] adc;
  int num_errors = 0, checked = 0, n1 = 0, n21 = 0, n31 = 0, nirq = 0, nx = 0;
  logic [15:0] prog [8] = '{16'h7295, 16'h603a, 16'h8143, 16'h53c5, 16'h0b9f, 16'h957c, 16'h0e1d, 16'h00ae};

  step_sequencer dut (.CLK_I(clk), .RESET_N_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rd_d), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .TRIG_SRC_I(src), .TRIG_OUT_O(trig), .IRQ_OUT_O(irq), .ADC_CHANNEL_SELECT_O(adc), .BUSY_O(busy));
  periph_model peri (.clk_i(clk), .reset_n_i(rst_n), .level_i(lvl), .src_o(src));

  // pulse counters; any stray output pulse counts in nx
  always @(posedge clk) begin
    n1 <= n1 + trig[1];
    n21 <= n21 + trig[21];
    n31 <= n31 + trig[31];
    nirq <= nirq + irq[2];
    nx <= nx + (|(trig & ~32'h8020_0002)) + (|(irq & 4'hb));
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // write: aw and w offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    @(posedge clk);
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) hang();
  endtask

  // read: address held until arready, data taken with rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    int n;
    @(posedge clk);
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      d = rd_d;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    if (!tr) hang();
  endtask

  task automatic t_regs();
    logic [31:0] d;
    axi_rd(HOLD_OFF, d);
    chk(d, 32'h0, "hold reset");
    axi_rd(8'h38, d);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped resp");
    axi_wr(HOLD_OFF, 32'h1234);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "write resp");
    axi_rd(HOLD_OFF, d);
    chk(d, 32'h1234, "hold rw");
    $display("test regs done");
  endtask

  // program: trig21, irq2, strobe 1a, nop, wait rise 3, trig1 looped, wait fall 3, trig31,
  // wait soft bit, reserved irq, trig21, copy hold to literal, literal to adc select, park
  task automatic t_prog();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) axi_wr(QUEUE_OFF + 8'(4 * i), {16'h0, prog[i]});
    axi_wr(C0LIM_OFF, 32'h2);
    axi_wr(QPTR_OFF, 32'h0);
    axi_wr(CTRL_OFF, 32'h3);
    repeat (20) @(posedge clk);
    chk(n21, 1, "trig 21 pulses");
    chk(nirq, 1, "irq 2 pulses");
    chk({26'h0, adc}, 32'h1a, "adc select");
    chk(n1, 0, "trig 1 before edge");
    chk({31'h0, busy}, 32'h1, "busy in wait");
    axi_wr(HOLD_OFF, 32'hbeef);
    axi_rd(HOLD_OFF, d);
    chk(d, 32'h1234, "hold locked");
    lvl <= 16'h0008;
    repeat (40) @(posedge clk);
    chk(n1, 3, "loop pulses");
    chk(n31, 0, "trig 31 before fall");
    lvl <= 16'h0000;
    repeat (20) @(posedge clk);
    chk(n31, 1, "trig 31 after fall");
    chk(n21, 1, "trig 21 before soft bit");
    axi_wr(CTRL_OFF, 32'h7);
    repeat (20) @(posedge clk);
    chk(n21, 2, "trig 21 after soft bit");
    chk({26'h0, adc}, 32'h34, "literal to adc select");
    chk(nx, 0, "stray pulses");
    $display("test program done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    lvl = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_prog();
    print_verdict();
  end
endmodule

/* File: step_sequencer.sv */
// step command sequencer: queue, decoder, executor and register slave
// Overview of operation
// - step byte is command nibble over operand nibble; code 0000 does control actions
// - code 0001 operands 0-5 add adjust value to a limit or literal
// - operands 8-13 copy hold value to the same six targets
// - codes 001x write five-bit value into adc channel select field
// - code 0100 waits for rising edge on selected trigger input
// - code 0101 waits for falling edge on selected trigger input
// - reserved codes and operands execute as a step with no effect
// - code 0111 raises interrupt 0 to 3; higher operands reserved
// - codes 100x pulse one of 32 trigger outputs
// - codes 101x load queue pointer with five-bit target
// - codes 110x loop on counter 0 until it equals its limit
// - codes 111x same loop using counter 1 and its limit
// - control 0010 disables step delay timer, 0110 enables it
// - control 1000/1001 start timer 0/1 and wait for its limit
// - control 1011 waits for software trigger bit rising
// - control 1100-1110 copy counter 0, counter 1 or literal to adc select
// - control 1111 pulses all broadcast enabled trigger outputs at once
// - edge wait operand selects one of 16 peripheral sources
// - outputs 0-12 feed compare, capture and adc triggers
// - outputs 16-19 sync pwm time bases
// - outputs 26-31 feed logic cells and remap inputs; others reserved
// - with delay enabled each step that does not wait lasts delay limit plus one clock
// - queue holds 32 bytes, two per 16-bit word, even step low
// - while enabled and started, configuration registers are read-only
module step_sequencer
  import seq_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic [15:0] TRIG_SRC_I,
  output logic [31:0]      TRIG_OUT_O,
  output logic [3:0]       IRQ_OUT_O,
  output logic [5:0]       ADC_CHANNEL_SELECT_O,
  output logic             BUSY_O
);
  // ---- state
  logic [DW-1:0] t0lim_reg, t1lim_reg, sdlim_reg, c0lim_reg, c1lim_reg;
  logic [DW-1:0] hold_reg, adj_reg, lit0_reg, c0_reg, c1_reg, sdcnt_reg;
  logic [31:0]   bte_reg;
  logic [15:0]   queue_reg [16];
  logic [4:0]    qptr_reg;
  logic [3:0]    ctrl_reg;
  logic          sd_en_reg;
  logic [5:0]    adcsel_reg;
  pulse_t        pulse_reg;
  seq_state_t    state_reg;
  logic [15:0]   src_prev_reg;
  logic          swt_prev_reg;
  logic          waited_reg;
  logic          awtaken_reg, wtaken_reg, bvalid_reg;
  logic          awready_reg, wready_reg;
  logic [7:0]    awaddr_reg;
  logic [31:0]   wdata_reg;
  logic          arready_reg, rvalid_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    rresp_reg, bresp_reg;

  // ---- decode of the current step byte
  wire logic          running  = ctrl_reg[CTRL_EN_BIT] & ctrl_reg[CTRL_START_BIT];
  wire logic          locked   = running;
  wire logic [15:0]   qword    = queue_reg[qptr_reg[4:1]];
  wire step_t         step     = qptr_reg[0] ? qword[15:8] : qword[7:0];
  wire logic [4:0]    imm5     = {step.cmd[0], step.opt};
  wire logic [4:0]    qnext    = qptr_reg + 5'h01;
  wire logic          is_ctrl  = step.cmd == CMD_CONTROL;
  wire logic          is_wait  = (step.cmd == CMD_WAITHI) || (step.cmd == CMD_WAITLO) ||
                                 (is_ctrl && (step.opt == OPT_TMR0 || step.opt == OPT_TMR1 ||
                                              step.opt == OPT_SWT));
  wire logic          src_now  = TRIG_SRC_I[step.opt];
  wire logic          src_old  = src_prev_reg[step.opt];
  wire logic          rise_hit = src_now & ~src_old;
  wire logic          fall_hit = ~src_now & src_old;
  wire logic          swt_hit  = ctrl_reg[CTRL_SWT_BIT] & ~swt_prev_reg;
  wire logic          t0_done, t1_done;
  wire logic          t0_start = (state_reg == ST_EXEC) && is_ctrl && step.opt == OPT_TMR0;
  wire logic          t1_start = (state_reg == ST_EXEC) && is_ctrl && step.opt == OPT_TMR1;
  wire logic          wait_met = (step.cmd == CMD_WAITHI) ? rise_hit :
                                 (step.cmd == CMD_WAITLO) ? fall_hit :
                                 (step.opt == OPT_TMR0)   ? t0_done  :
                                 (step.opt == OPT_TMR1)   ? t1_done  : swt_hit;
  wire logic          loop0_hit = c0_reg == c0lim_reg;
  wire logic          loop1_hit = c1_reg == c1lim_reg;
  // pointer after the step: jumps and loops whose counter is not yet at its limit load imm5, everything else advances
  wire logic [4:0]    qptr_after =
      (step.cmd[3:1] == CMD_JUMP)                 ? imm5 :
      (step.cmd[3:1] == CMD_LOOP0 && !loop0_hit)  ? imm5 :
      (step.cmd[3:1] == CMD_LOOP1 && !loop1_hit)  ? imm5 :
      qnext;

  step_timer #(.W(DW)) u_timer0 (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .start_i   (t0_start),
    .limit_i   (t0lim_reg),
    .done_o    (t0_done)
  );
  step_timer #(.W(DW)) u_timer1 (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .start_i   (t1_start),
    .limit_i   (t1lim_reg),
    .done_o    (t1_done)
  );

  // ---- bus write decode; sequencer updates take priority only when locked
  wire logic       wr_fire  = awtaken_reg & wtaken_reg & ~bvalid_reg;
  wire logic       wr_cfg   = wr_fire & ~locked;
  wire logic       wr_queue = (awaddr_reg >= QUEUE_OFF) && (awaddr_reg <= QUEUE_END);
  wire logic [3:0] wr_qidx  = 4'(awaddr_reg[7:2] - QUEUE_OFF[7:2]);
  wire logic [DW-1:0] wval  = wdata_reg[DW-1:0];
  wire logic       wr_known = wr_queue || awaddr_reg <= ADCSEL_OFF;
  // step completes this cycle (exec or wait satisfied) and delay is not pending
  wire logic       exec_now = state_reg == ST_EXEC;
  wire logic       step_end = (exec_now && !is_wait) || (state_reg == ST_WAIT && wait_met);
  wire logic       do_step  = exec_now; // side effects happen once, on entry
  wire logic       add_op   = do_step && step.cmd == CMD_ADDCOPY && !step.opt[3] &&
                              step.opt[2:0] <= TGT_LAST;
  wire logic       cpy_op   = do_step && step.cmd == CMD_ADDCOPY && step.opt[3] &&
                              step.opt[2:0] <= TGT_LAST;
  wire logic [DW-1:0] tgt_cur [6] = '{c0lim_reg, c1lim_reg, t0lim_reg, t1lim_reg, sdlim_reg, lit0_reg};
  wire logic [DW-1:0] op_val = add_op ? DW'(tgt_cur[step.opt[2:0]] + adj_reg) : hold_reg;
  wire logic [5:0] tgt_hit  = (add_op || cpy_op) ? 6'(6'h01 << step.opt[2:0]) : 6'h00;

  // ---- sequencer state machine
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_IDLE;
      qptr_reg  <= '0;
      sdcnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE:  if (running) state_reg <= ST_EXEC;
        ST_EXEC, ST_WAIT: begin
          if (!running) begin
            state_reg <= ST_IDLE;
          end else if (step_end) begin
            qptr_reg <= qptr_after;
            if (sd_en_reg && sdlim_reg != '0) begin
              sdcnt_reg <= DW'(1);
              state_reg <= ST_DELAY;
            end else begin
              state_reg <= ST_EXEC;
            end
          end else if (exec_now) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_DELAY: begin
          if (!running) state_reg <= ST_IDLE;
          else if (sdcnt_reg >= sdlim_reg) state_reg <= ST_EXEC;
          else sdcnt_reg <= sdcnt_reg + DW'(1);
        end
      endcase
      if (!running && wr_cfg && awaddr_reg == QPTR_OFF) qptr_reg <= wval[4:0];
    end
  end

  // ---- edge history of the trigger sources and the software bit
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      src_prev_reg <= '0;
      swt_prev_reg <= 1'b0;
      waited_reg   <= 1'b0;
    end else begin
      src_prev_reg <= TRIG_SRC_I;
      swt_prev_reg <= ctrl_reg[CTRL_SWT_BIT];
      waited_reg   <= state_reg == ST_WAIT;
    end
  end

  // ---- limit registers: step writes when running, bus writes otherwise
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      {c0lim_reg, c1lim_reg, t0lim_reg, t1lim_reg, sdlim_reg, lit0_reg} <= '0;
      {hold_reg, adj_reg} <= '0;
      bte_reg <= '0;
    end else begin
      if (tgt_hit[0]) c0lim_reg <= op_val;
      if (tgt_hit[1]) c1lim_reg <= op_val;
      if (tgt_hit[2]) t0lim_reg <= op_val;
      if (tgt_hit[3]) t1lim_reg <= op_val;
      if (tgt_hit[4]) sdlim_reg <= op_val;
      if (tgt_hit[5]) lit0_reg  <= op_val;
      if (wr_cfg) begin
        unique case (awaddr_reg)
          C0LIM_OFF: c0lim_reg <= wval;
          C1LIM_OFF: c1lim_reg <= wval;
          T0LIM_OFF: t0lim_reg <= wval;
          T1LIM_OFF: t1lim_reg <= wval;
          SDLIM_OFF: sdlim_reg <= wval;
          LIT0_OFF:  lit0_reg  <= wval;
          HOLD_OFF:  hold_reg  <= wval;
          ADJ_OFF:   adj_reg   <= wval;
          BTE_OFF:   bte_reg   <= wdata_reg;
          default: ;
        endcase
      end
    end
  end

  // ---- queue storage; every word clears to REG_RESET (zero) on reset
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < 16; i++) queue_reg[i] <= REG_RESET;
    end else if (wr_cfg && wr_queue) begin
      queue_reg[wr_qidx] <= wdata_reg[15:0];
    end
  end

  // ---- control register, delay enable, loop counters, adc select, pulses
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ctrl_reg   <= '0;
      sd_en_reg  <= 1'b0;
      c0_reg     <= '0;
      c1_reg     <= '0;
      adcsel_reg <= '0;
      pulse_reg  <= '0;
    end else begin
      pulse_reg <= '0;
      if (wr_fire && awaddr_reg == CTRL_OFF) begin
        ctrl_reg <= wdata_reg[3:0]; // control stays writable to allow stop
        if (!locked) sd_en_reg <= wdata_reg[CTRL_SDEN_BIT];
      end
      if (do_step) begin
        if (is_ctrl && step.opt == OPT_SD_OFF) sd_en_reg <= 1'b0;
        if (is_ctrl && step.opt == OPT_SD_ON)  sd_en_reg <= 1'b1;
        if (is_ctrl && step.opt == OPT_CPY_C0) adcsel_reg <= c0_reg[5:0];
        if (is_ctrl && step.opt == OPT_CPY_C1) adcsel_reg <= c1_reg[5:0];
        if (is_ctrl && step.opt == OPT_CPY_L0) adcsel_reg <= lit0_reg[5:0];
        if (is_ctrl && step.opt == OPT_BCAST)  pulse_reg.trig <= bte_reg;
        if (step.cmd[3:1] == CMD_STROBE) adcsel_reg <= {1'b0, imm5};
        if (step.cmd == CMD_IRQ && step.opt <= OPT_IRQ_MAX)
          pulse_reg.irq <= 4'(4'h1 << step.opt[1:0]);
        if (step.cmd[3:1] == CMD_TRIG)
          pulse_reg.trig <= 32'(32'h1 << imm5);
        if (step.cmd[3:1] == CMD_LOOP0) c0_reg <= loop0_hit ? '0 : c0_reg + DW'(1);
        if (step.cmd[3:1] == CMD_LOOP1) c1_reg <= loop1_hit ? '0 : c1_reg + DW'(1);
      end
      if (wr_cfg && awaddr_reg == CNT_OFF) begin
        c0_reg <= '0;
        c1_reg <= '0;
      end
    end
  end

  // ---- AXI4-Lite write channel: address and data in either order
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      awtaken_reg <= 1'b0;
      wtaken_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
    end else begin
      // ready is a one-cycle registered pulse; items are taken only at their handshake edge
      awready_reg <= AWVALID_I && !awready_reg && !awtaken_reg && !bvalid_reg;
      wready_reg  <= WVALID_I && !wready_reg && !wtaken_reg && !bvalid_reg;
      if (AWVALID_I && awready_reg) begin
        awtaken_reg <= 1'b1;
        awaddr_reg  <= {AWADDR_I[7:2], 2'b00};
      end
      if (WVALID_I && wready_reg) begin
        wtaken_reg <= 1'b1;
        wdata_reg  <= WDATA_I;
      end
      if (wr_fire) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
        awtaken_reg <= 1'b0;
        wtaken_reg  <= 1'b0;
      end else if (bvalid_reg && BREADY_I) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ---- AXI4-Lite read channel
  wire logic [7:0]  ra     = {ARADDR_I[7:2], 2'b00};
  wire logic        rd_q   = (ra >= QUEUE_OFF) && (ra <= QUEUE_END);
  wire logic [3:0]  rd_qi  = 4'(ra[7:2] - QUEUE_OFF[7:2]);
  wire logic [31:0] status = {21'h0, waited_reg, sd_en_reg, state_reg, 1'b0, qptr_reg, running};
  wire logic [31:0] rd_val =
      rd_q               ? {16'h0, queue_reg[rd_qi]} :
      ra == CTRL_OFF     ? {28'h0, ctrl_reg} :
      ra == STATUS_OFF   ? status :
      ra == BTE_OFF      ? bte_reg :
      ra == T0LIM_OFF    ? {16'h0, t0lim_reg} :
      ra == T1LIM_OFF    ? {16'h0, t1lim_reg} :
      ra == SDLIM_OFF    ? {16'h0, sdlim_reg} :
      ra == C0LIM_OFF    ? {16'h0, c0lim_reg} :
      ra == C1LIM_OFF    ? {16'h0, c1lim_reg} :
      ra == HOLD_OFF     ? {16'h0, hold_reg} :
      ra == ADJ_OFF      ? {16'h0, adj_reg} :
      ra == LIT0_OFF     ? {16'h0, lit0_reg} :
      ra == QPTR_OFF     ? {27'h0, qptr_reg} :
      ra == CNT_OFF      ? {c1_reg, c0_reg} :
      ra == ADCSEL_OFF   ? {26'h0, adcsel_reg} : 32'h0;
  wire logic        rd_ok  = rd_q || ra <= ADCSEL_OFF;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= ARVALID_I && !arready_reg && !rvalid_reg;
      // data follows the address handshake, never precedes it
      if (ARVALID_I && arready_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_val;
        rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && RREADY_I) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---- outputs straight from flip-flops
  assign AWREADY_O            = awready_reg;
  assign WREADY_O             = wready_reg;
  assign BVALID_O             = bvalid_reg;
  assign BRESP_O              = bresp_reg;
  assign ARREADY_O            = arready_reg;
  assign RVALID_O             = rvalid_reg;
  assign RDATA_O              = rdata_reg;
  assign RRESP_O              = rresp_reg;
  assign TRIG_OUT_O           = pulse_reg.trig;
  assign IRQ_OUT_O            = pulse_reg.irq;
  assign ADC_CHANNEL_SELECT_O = adcsel_reg;
  assign BUSY_O               = waited_reg;

  // ---- assertions
  property p_trig_onehot;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (do_step && step.cmd[3:1] == CMD_TRIG) |=> $onehot(TRIG_OUT_O);
  endproperty
  a_trig_onehot: assert property (p_trig_onehot) else $error("trigger pulse not one-hot");

  property p_trig_short;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (TRIG_OUT_O != '0) |=> (TRIG_OUT_O == '0) || $past(do_step);
  endproperty
  a_trig_short: assert property (p_trig_short) else $error("trigger held too long");

  property p_irq_range;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (do_step && step.cmd == CMD_IRQ && step.opt > OPT_IRQ_MAX) |=> IRQ_OUT_O == 4'h0;
  endproperty
  a_irq_range: assert property (p_irq_range) else $error("reserved irq operand fired");

  property p_jump;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (exec_now && running && step.cmd[3:1] == CMD_JUMP) |=> qptr_reg == $past(imm5);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  property p_advance;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (step_end && running && !step.cmd[3]) |=> qptr_reg == $past(qnext);
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance");

  property p_strobe;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (do_step && step.cmd[3:1] == CMD_STROBE) |=> ADC_CHANNEL_SELECT_O == {1'b0, $past(imm5)};
  endproperty
  a_strobe: assert property (p_strobe) else $error("channel select not written");

  property p_lock;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (locked && wr_fire && awaddr_reg == HOLD_OFF) |=> $stable(hold_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed");

  property p_sd_off;
    @(posedge CLK_I) disable iff (!RESET_N_I)
      (do_step && is_ctrl && step.opt == OPT_SD_OFF) |=> !sd_en_reg;
  endproperty
  a_sd_off: assert property (p_sd_off) else $error("delay timer not disabled");
endmodule

/* File: step_timer.sv */
// general timer that runs from start until it matches its limit
module step_timer
  import seq_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);
  logic [W-1:0] count_reg;
  logic         run_reg;

  // count up from zero; done is a one-cycle pulse on match
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
    end else if (start_i) begin
      count_reg <= '0;
      run_reg   <= 1'b1;
    end else if (run_reg) begin
      if (count_reg == limit_i) begin
        run_reg <= 1'b0;
      end else begin
        count_reg <= count_reg + W'(1);
      end
    end
  end

  assign done_o = run_reg && (count_reg == limit_i) && !start_i;
endmodule
